/* File: pkg/pinctl_pkg.sv */
// Purpose: Shared constants and types for the reset and alarm pin logic
// Assumes: 125 MHz core clock, 32-bit AXI4-Lite register bus
// Notes:   Offsets are byte addresses, one aligned word per register
package pinctl_pkg;
   // Bus geometry
   localparam int AXI_ADDR_W = 8;
   localparam int AXI_DATA_W = 32;
   localparam int REG_W      = 8;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Register offsets
   localparam logic [AXI_ADDR_W-1:0] CTRL_OFFSET       = 8'h00;
   localparam logic [AXI_ADDR_W-1:0] STATUS_OFFSET     = 8'h04;
   localparam logic [AXI_ADDR_W-1:0] IRQ_STATUS_OFFSET = 8'h08;
   localparam logic [AXI_ADDR_W-1:0] IRQ_MASK_OFFSET   = 8'h0C;
   // Control fields
   localparam int CTRL_IRQ_SEL_BIT    = 0;
   localparam int CTRL_IRQ_LEVEL_BIT  = 1;
   localparam int CTRL_IN1_ALARM_BIT  = 2;
   localparam int CTRL_IN2_ALARM_BIT  = 3;
   localparam int CTRL_ALARM_LVL_BIT  = 4;
   localparam int CTRL_CLK_EN_BIT     = 5;
   localparam int CTRL_SOFT_RST_BIT   = 7;
   localparam logic [REG_W-1:0] CTRL_RESET   = 8'h00;
   localparam logic [REG_W-1:0] CTRL_WR_MASK = 8'h3F;
   // Status fields
   localparam int STAT_LOSS1_BIT = 0;
   localparam int STAT_LOSS2_BIT = 1;
   localparam int STAT_REF_LSB   = 2;
   localparam int STAT_BUSY_BIT  = 4;
   localparam int STAT_CLK_ON_BIT = 5;
   // Interrupt events
   localparam int IRQ_N          = 4;
   localparam int EV_LOSS1_SET   = 0;
   localparam int EV_LOSS2_SET   = 1;
   localparam int EV_LOSS1_CLR   = 2;
   localparam int EV_LOSS2_CLR   = 3;
   localparam logic [IRQ_N-1:0] IRQ_MASK_RESET = 4'h0;
   // Conditioned pin inputs
   localparam int SYN_N         = 5;
   localparam int SYN_EXT_RST_N = 0;
   localparam int SYN_LOSS1     = 1;
   localparam int SYN_LOSS2     = 2;
   localparam int SYN_REF_MID   = 3;
   localparam int SYN_REF_HI    = 4;
   localparam logic [SYN_N-1:0] SYN_RESET = 5'h01;
   // Timing, clock output count and shared enums
   localparam int CLK_FREQ_MHZ   = 125;
   localparam int RST_WAIT_MS    = 10;
   localparam int RST_WAIT_CYC   = RST_WAIT_MS * 1000 * CLK_FREQ_MHZ;
   localparam int NUM_CLK_OUT    = 2;
   typedef enum logic [1:0] {
      REF_XTAL     = 2'b00,
      REF_EXT_CLK  = 2'b01,
      REF_RESERVED = 2'b10
   } ref_type_t;
   typedef enum logic [1:0] {
      ST_RUN       = 2'b00,
      ST_PIN_RESET = 2'b01,
      ST_SOFT_WAIT = 2'b10
   } seq_state_t;
endpackage

/* File: pkg/sync_if.sv */
// Purpose: Carrier between the pin owner and the input conditioner
// Assumes: raw bits are asynchronous to the core clock
// Notes:   clean bits are stable core-clock levels
`timescale 1ns/1ps
`default_nettype none
interface sync_if #(
   parameter int N = 5
);
   logic [N-1:0] raw;
   logic [N-1:0] clean;
   modport owner       (output raw, input clean);
   modport conditioner (input raw, output clean);
endinterface
`default_nettype wire

/* File: src/pin_sync.sv */
// Purpose: Three-stage synchroniser with agreement filter for pin inputs
// Assumes: Inputs may change at any time relative to the clock
// Notes:   A bit changes once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int           N       = 5,
   parameter logic [N-1:0] RST_VAL = '0
) (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       arst_n_i,
   // Pin bits in, clean bits out
   sync_if.conditioner     port_if
);
   typedef struct packed {
      logic [N-1:0] s1;
      logic [N-1:0] s2;
      logic [N-1:0] s3;
      logic [N-1:0] clean;
   } sync_state_t;

   sync_state_t q;
   sync_state_t next_q;

   always_comb begin
      next_q       = q;
      next_q.s1    = port_if.raw;
      next_q.s2    = q.s1;
      next_q.s3    = q.s2;
      // Disagreement holds the old level, filtering a one-cycle blip
      next_q.clean = ((q.s2 ~^ q.s3) & q.s2) | ((q.s2 ^ q.s3) & q.clean);
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         q <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, clean: RST_VAL};
      end else begin
         q <= next_q;
      end
   end

   assign port_if.clean = q.clean;
endmodule
`default_nettype wire

/* File: src/reset_alarm_pins.sv */
// Purpose: Reset, alarm and interrupt pin logic of a clock multiplier
// Assumes: Pin inputs are asynchronous; bus is AXI4-Lite on CORE_CLK_I
// Notes:   Bus handshake survives pad and soft reset
//
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module reset_alarm_pins
   import pinctl_pkg::*;
#(
   parameter int unsigned RST_WAIT_CYCLES = pinctl_pkg::RST_WAIT_CYC,
   parameter int unsigned CLK_OUTS        = pinctl_pkg::NUM_CLK_OUT
) (
   // Clock and reset
   input  wire logic                              CORE_CLK_I,
   input  wire logic                              ARST_N_I,
   // AXI4-Lite write address
   input  wire logic                              AWVALID_I,
   output logic                                   AWREADY_O,
   input  wire logic [pinctl_pkg::AXI_ADDR_W-1:0] AWADDR_I,
   // AXI4-Lite write data
   input  wire logic                              WVALID_I,
   output logic                                   WREADY_O,
   input  wire logic [pinctl_pkg::AXI_DATA_W-1:0] WDATA_I,
   input  wire logic [3:0]                        WSTRB_I,
   // AXI4-Lite write response
   output logic                                   BVALID_O,
   input  wire logic                              BREADY_I,
   output logic [1:0]                             BRESP_O,
   // AXI4-Lite read address
   input  wire logic                              ARVALID_I,
   output logic                                   ARREADY_O,
   input  wire logic [pinctl_pkg::AXI_ADDR_W-1:0] ARADDR_I,
   // AXI4-Lite read data
   output logic                                   RVALID_O,
   input  wire logic                              RREADY_I,
   output logic [pinctl_pkg::AXI_DATA_W-1:0]      RDATA_O,
   output logic [1:0]                             RRESP_O,
   // External reset pin
   input  wire logic                              EXT_RESET_N_I,
   input  wire logic                              EXT_RESET_DRIVEN_I,
   // Loss detector and reference type pins
   input  wire logic                              IN1_LOSS_I,
   input  wire logic                              IN2_LOSS_I,
   input  wire logic                              REF_LEVEL_MID_I,
   input  wire logic                              REF_LEVEL_HI_I,
   // Alarm pins
   output logic                                   IRQ_OR_IN1_LOSS_OUT_O,
   output logic                                   IRQ_OR_IN1_LOSS_OE_N_O,
   output logic                                   IN2_LOSS_OUT_O,
   output logic                                   IN2_LOSS_OE_N_O,
   // Clock output enables, reference type and reset busy
   output logic [CLK_OUTS-1:0]                    CLK_OUT_OE_N_O,
   output logic [1:0]                             REF_TYPE_O,
   output logic                                   RESET_BUSY_O,
   // System interrupt
   output logic                                   IRQ_O
);
   import pinctl_pkg::*;

   localparam int WAIT_W = $clog2(RST_WAIT_CYCLES + 1);
   localparam logic [WAIT_W-1:0] WAIT_LOAD = WAIT_W'(RST_WAIT_CYCLES - 1);

   typedef struct packed {
      seq_state_t                seq;
      logic [WAIT_W-1:0]         wait_cnt;
      logic [REG_W-1:0]          ctrl;
      logic [IRQ_N-1:0]          irq_st;
      logic [IRQ_N-1:0]          irq_mask;
      logic [1:0]                loss_prev;
      ref_type_t                 ref_type;
      logic                      aw_held;
      logic [AXI_ADDR_W-1:0]     aw_addr;
      logic                      w_held;
      logic [REG_W-1:0]          w_data;
      logic                      w_lane0;
      logic                      bvalid;
      logic [1:0]                bresp;
      logic                      rvalid;
      logic [REG_W-1:0]          rdata;
      logic [1:0]                rresp;
      logic                      pin1_out;
      logic                      pin1_oe_n;
      logic                      pin2_out;
      logic                      pin2_oe_n;
      logic [CLK_OUTS-1:0]       ck_oe_n;
      logic                      irq;
   } state_t;

   localparam state_t STATE_RESET = '{
      seq:       ST_RUN,
      wait_cnt:  '0,
      ctrl:      CTRL_RESET,
      irq_st:    '0,
      irq_mask:  IRQ_MASK_RESET,
      loss_prev: '0,
      ref_type:  REF_XTAL,
      aw_held:   1'b0,
      aw_addr:   '0,
      w_held:    1'b0,
      w_data:    '0,
      w_lane0:   1'b0,
      bvalid:    1'b0,
      bresp:     RESP_OKAY,
      rvalid:    1'b0,
      rdata:     '0,
      rresp:     RESP_OKAY,
      pin1_out:  1'b0,
      pin1_oe_n: 1'b1,
      pin2_out:  1'b0,
      pin2_oe_n: 1'b1,
      ck_oe_n:   '1,
      irq:       1'b0
   };

   // Polarity by inversion of an already settled level
   function automatic logic apply_level(input logic level, input logic active_high);
      apply_level = active_high ? level : ~level;
   endfunction

   function automatic logic is_mapped(input logic [AXI_ADDR_W-1:0] addr);
      is_mapped = (addr == CTRL_OFFSET) || (addr == STATUS_OFFSET)
               || (addr == IRQ_STATUS_OFFSET) || (addr == IRQ_MASK_OFFSET);
   endfunction

   // Comparator pair of the three-level pin; a high without mid is taken as reserved
   function automatic ref_type_t decode_ref(input logic mid, input logic hi);
      case ({hi, mid})
         2'b00:   decode_ref = REF_XTAL;
         2'b01:   decode_ref = REF_EXT_CLK;
         default: decode_ref = REF_RESERVED;
      endcase
   endfunction

   state_t             q;
   state_t             next_q;
   logic               ext_rst_n_pad;
   logic               pin_rst;
   logic [1:0]         loss_now;
   logic [IRQ_N-1:0]   events;
   logic               aw_ready;
   logic               w_ready;
   logic               ar_ready;
   logic               do_wr;
   logic               wr_lane;
   logic               soft_req;
   logic               in_reset;
   logic [REG_W-1:0]   status_word;

   sync_if #(.N(SYN_N)) syn ();

   // Pull-up wins whenever nobody drives the pad
   assign ext_rst_n_pad = EXT_RESET_DRIVEN_I ? EXT_RESET_N_I : 1'b1;

   assign syn.raw[SYN_EXT_RST_N] = ext_rst_n_pad;
   assign syn.raw[SYN_LOSS1]     = IN1_LOSS_I;
   assign syn.raw[SYN_LOSS2]     = IN2_LOSS_I;
   assign syn.raw[SYN_REF_MID]   = REF_LEVEL_MID_I;
   assign syn.raw[SYN_REF_HI]    = REF_LEVEL_HI_I;

   pin_sync #(
      .N       (SYN_N),
      .RST_VAL (SYN_RESET)
   ) u_pin_sync (
      .clk_i    (CORE_CLK_I),
      .arst_n_i (ARST_N_I),
      .port_if  (syn.conditioner)
   );

   assign pin_rst  = ~syn.clean[SYN_EXT_RST_N];
   assign loss_now = {syn.clean[SYN_LOSS2], syn.clean[SYN_LOSS1]};
   assign events[EV_LOSS1_SET] = loss_now[0] & ~q.loss_prev[0];
   assign events[EV_LOSS2_SET] = loss_now[1] & ~q.loss_prev[1];
   assign events[EV_LOSS1_CLR] = ~loss_now[0] & q.loss_prev[0];
   assign events[EV_LOSS2_CLR] = ~loss_now[1] & q.loss_prev[1];

   // One transfer of each kind at a time; response must drain first
   assign aw_ready = ~q.aw_held & ~q.bvalid;
   assign w_ready  = ~q.w_held & ~q.bvalid;
   assign ar_ready = ~q.rvalid;

   assign status_word = {
      2'b00,
      q.ck_oe_n[0] == 1'b0,
      q.seq == ST_SOFT_WAIT,
      q.ref_type,
      q.loss_prev
   };

   always_comb begin
      next_q   = q;
      do_wr    = 1'b0;
      wr_lane  = 1'b0;
      soft_req = 1'b0;
      in_reset = 1'b0;

      // Write channels, taken in either order
      if (AWVALID_I && aw_ready) begin
         next_q.aw_held = 1'b1;
         next_q.aw_addr = AWADDR_I;
      end
      if (WVALID_I && w_ready) begin
         next_q.w_held  = 1'b1;
         next_q.w_data  = WDATA_I[REG_W-1:0];
         next_q.w_lane0 = WSTRB_I[0];
      end
      if (q.bvalid && BREADY_I) begin
         next_q.bvalid = 1'b0;
      end
      do_wr   = next_q.aw_held & next_q.w_held & ~q.bvalid;
      wr_lane = do_wr & next_q.w_lane0;
      if (do_wr) begin
         next_q.aw_held = 1'b0;
         next_q.w_held  = 1'b0;
         next_q.bvalid  = 1'b1;
         next_q.bresp   = is_mapped(next_q.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end

      // Status sticky bits: a new event beats a same-cycle clear
      next_q.irq_st = q.irq_st | events;
      if (wr_lane && next_q.aw_addr == IRQ_STATUS_OFFSET) begin
         next_q.irq_st = (q.irq_st & ~next_q.w_data[IRQ_N-1:0]) | events;
      end
      if (wr_lane && next_q.aw_addr == IRQ_MASK_OFFSET) begin
         next_q.irq_mask = next_q.w_data[IRQ_N-1:0];
      end
      if (wr_lane && next_q.aw_addr == CTRL_OFFSET) begin
         next_q.ctrl = next_q.w_data & CTRL_WR_MASK;
         soft_req    = next_q.w_data[CTRL_SOFT_RST_BIT];
      end
      next_q.loss_prev = loss_now;
      next_q.ref_type  = decode_ref(syn.clean[SYN_REF_MID], syn.clean[SYN_REF_HI]);

      // Read channel
      if (q.rvalid && RREADY_I) begin
         next_q.rvalid = 1'b0;
      end
      if (ARVALID_I && ar_ready) begin
         next_q.rvalid = 1'b1;
         next_q.rresp  = is_mapped(ARADDR_I) ? RESP_OKAY : RESP_SLVERR;
         case (ARADDR_I)
            CTRL_OFFSET:       next_q.rdata = q.ctrl;
            STATUS_OFFSET:     next_q.rdata = status_word;
            IRQ_STATUS_OFFSET: next_q.rdata = REG_W'(q.irq_st);
            IRQ_MASK_OFFSET:   next_q.rdata = REG_W'(q.irq_mask);
            default:           next_q.rdata = '0;
         endcase
      end

      // Reset sequencer
      case (q.seq)
         ST_RUN: begin
            if (pin_rst) begin
               next_q.seq = ST_PIN_RESET;
            end else if (soft_req) begin
               next_q.seq      = ST_SOFT_WAIT;
               next_q.wait_cnt = WAIT_LOAD;
            end
         end
         ST_PIN_RESET: begin
            if (!pin_rst) begin
               next_q.seq = ST_RUN;
            end
         end
         ST_SOFT_WAIT: begin
            if (pin_rst) begin
               next_q.seq = ST_PIN_RESET;
            end else if (soft_req) begin
               next_q.wait_cnt = WAIT_LOAD;
            end else if (q.wait_cnt == '0) begin
               next_q.seq = ST_RUN;
            end else begin
               next_q.wait_cnt = q.wait_cnt - 1'b1;
            end
         end
         default: begin
            next_q.seq = ST_RUN;
         end
      endcase

      // Bus handshake state survives so a pending answer is never lost
      in_reset = pin_rst | soft_req;
      if (in_reset) begin
         next_q.ctrl     = CTRL_RESET;
         next_q.irq_st   = '0;
         next_q.irq_mask = IRQ_MASK_RESET;
      end

      // Pin drive, from settled state only
      next_q.irq = |(next_q.irq_st & next_q.irq_mask);
      if (next_q.ctrl[CTRL_IRQ_SEL_BIT]) begin
         next_q.pin1_oe_n = 1'b0;
         next_q.pin1_out  = apply_level(next_q.irq, next_q.ctrl[CTRL_IRQ_LEVEL_BIT]);
      end else if (next_q.ctrl[CTRL_IN1_ALARM_BIT]) begin
         next_q.pin1_oe_n = 1'b0;
         next_q.pin1_out  = apply_level(loss_now[0], next_q.ctrl[CTRL_ALARM_LVL_BIT]);
      end else begin
         next_q.pin1_oe_n = 1'b1;
         next_q.pin1_out  = 1'b0;
      end
      if (next_q.ctrl[CTRL_IN2_ALARM_BIT]) begin
         next_q.pin2_oe_n = 1'b0;
         next_q.pin2_out  = apply_level(loss_now[1], next_q.ctrl[CTRL_ALARM_LVL_BIT]);
      end else begin
         next_q.pin2_oe_n = 1'b1;
         next_q.pin2_out  = 1'b0;
      end

      // Clock outputs only after software enables them
      next_q.ck_oe_n = {CLK_OUTS{~next_q.ctrl[CTRL_CLK_EN_BIT] | in_reset}};
   end

   always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         q <= STATE_RESET;
      end else begin
         q <= next_q;
      end
   end

   // Handshake readies are combinational, payloads come from flops
   assign AWREADY_O              = aw_ready;
   assign WREADY_O               = w_ready;
   assign ARREADY_O              = ar_ready;
   assign BVALID_O               = q.bvalid;
   assign BRESP_O                = q.bresp;
   assign RVALID_O               = q.rvalid;
   assign RRESP_O                = q.rresp;
   assign RDATA_O                = {{(AXI_DATA_W - REG_W){1'b0}}, q.rdata};
   assign IRQ_OR_IN1_LOSS_OUT_O  = q.pin1_out;
   assign IRQ_OR_IN1_LOSS_OE_N_O = q.pin1_oe_n;
   assign IN2_LOSS_OUT_O         = q.pin2_out;
   assign IN2_LOSS_OE_N_O        = q.pin2_oe_n;
   assign CLK_OUT_OE_N_O         = q.ck_oe_n;
   assign REF_TYPE_O             = q.ref_type;
   assign RESET_BUSY_O           = (q.seq != ST_RUN);
   assign IRQ_O                  = q.irq;
endmodule
`default_nettype wire

/* File: verif/reset_alarm_pins_sva.sv */
// Purpose: Property checks on the reset and alarm pin block ports
// Assumes: One core clock domain, ARST_N_I active low
// Notes:   Pin latencies allow the three-stage input filter
`timescale 1ns/1ps
`default_nettype none
module reset_alarm_pins_sva
   import pinctl_pkg::*;
#(
   parameter int unsigned RST_WAIT_CYCLES = 20,
   parameter int unsigned CLK_OUTS        = 2
) (
   // Clock and reset
   input wire logic                  CORE_CLK_I,
   input wire logic                  ARST_N_I,
   // Bus handshakes
   input wire logic                  AWVALID_I,
   input wire logic                  AWREADY_O,
   input wire logic                  WVALID_I,
   input wire logic                  WREADY_O,
   input wire logic                  BVALID_O,
   input wire logic                  BREADY_I,
   input wire logic                  ARVALID_I,
   input wire logic                  ARREADY_O,
   input wire logic                  RVALID_O,
   input wire logic                  RREADY_I,
   input wire logic [AXI_DATA_W-1:0] RDATA_O,
   // Pads
   input wire logic                  EXT_RESET_N_I,
   input wire logic                  EXT_RESET_DRIVEN_I,
   input wire logic                  IN2_LOSS_I,
   input wire logic                  REF_LEVEL_MID_I,
   input wire logic                  REF_LEVEL_HI_I,
   // Pin outputs
   input wire logic                  IRQ_OR_IN1_LOSS_OE_N_O,
   input wire logic                  IN2_LOSS_OUT_O,
   input wire logic                  IN2_LOSS_OE_N_O,
   input wire logic [CLK_OUTS-1:0]   CLK_OUT_OE_N_O,
   input wire logic [1:0]            REF_TYPE_O,
   input wire logic                  RESET_BUSY_O,
   input wire logic                  IRQ_O
);
   default clocking cb @(posedge CORE_CLK_I);
   endclocking
   default disable iff (!ARST_N_I);

   write_answer_a: assert property (
      AWVALID_I && AWREADY_O && WVALID_I && WREADY_O |=> BVALID_O
   ) else $error("write response late");
   read_answer_a: assert property (ARVALID_I && ARREADY_O |=> RVALID_O)
      else $error("read data late");
   bresp_hold_a: assert property (BVALID_O && !BREADY_I |=> BVALID_O)
      else $error("write response dropped");
   rdata_hold_a: assert property (
      RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O)
   ) else $error("read data dropped or changed");
   rdata_upper_a: assert property (RVALID_O |-> RDATA_O[31:8] == 24'h00_0000)
      else $error("read data upper bits set");
   reset_release_a: assert property (
      $rose(ARST_N_I) |-> IRQ_OR_IN1_LOSS_OE_N_O && IN2_LOSS_OE_N_O && !IRQ_O
   ) else $error("pins driven after reset");
   pad_reset_a: assert property (
      (EXT_RESET_DRIVEN_I && !EXT_RESET_N_I)[*7] |-> RESET_BUSY_O &&
      IRQ_OR_IN1_LOSS_OE_N_O && IN2_LOSS_OE_N_O && (&CLK_OUT_OE_N_O)
   ) else $error("pad reset not honoured");
   busy_quiet_a: assert property (
      RESET_BUSY_O && $past(RESET_BUSY_O) |-> (&CLK_OUT_OE_N_O) && !IRQ_O
   ) else $error("outputs active during reset");
   loss_follow_a: assert property (
      ($changed(IN2_LOSS_I) && !IN2_LOSS_OE_N_O) ##1
      ($stable(IN2_LOSS_I) && !IN2_LOSS_OE_N_O)[*5]
      |-> IN2_LOSS_OUT_O != $past(IN2_LOSS_OUT_O, 5)
   ) else $error("loss pin did not follow input");
   ref_decode_a: assert property (
      ($stable(REF_LEVEL_MID_I) && $stable(REF_LEVEL_HI_I) && !RESET_BUSY_O)[*6]
      |-> REF_TYPE_O == (REF_LEVEL_HI_I ? REF_RESERVED
                         : (REF_LEVEL_MID_I ? REF_EXT_CLK : REF_XTAL))
   ) else $error("reference type decode wrong");
endmodule
bind reset_alarm_pins reset_alarm_pins_sva #(
   .RST_WAIT_CYCLES(RST_WAIT_CYCLES),
   .CLK_OUTS(CLK_OUTS)
) u_reset_alarm_pins_sva (.*);
`default_nettype wire

/* File: verif/reset_host_model.sv */
// Purpose: Board host that drives the reset pad and watches alarm pins
// Assumes: Reset pad has a weak pull-up
// Notes:   Released alarm pins read as z on their wires
`timescale 1ns/1ps
`default_nettype none
module reset_host_model (
   // Clock and command
   input  wire logic clk_i,
   input  wire logic hold_rst_i,
   // Alarm pins
   input  wire logic pin1_i,
   input  wire logic pin1_oe_n_i,
   input  wire logic pin2_i,
   input  wire logic pin2_oe_n_i,
   // Reset pad and alarm wires
   output var logic  pad_n_o,
   output var logic  pad_drv_o,
   output logic      wire1_o,
   output logic      wire2_o
);
   initial begin
      pad_n_o   = 1'b1;
      pad_drv_o = 1'b0;
   end
   // Released pad floats up, never to the last driven low
   always @(posedge clk_i) begin
      pad_drv_o <= hold_rst_i;
      pad_n_o   <= !hold_rst_i;
   end
   assign wire1_o = pin1_oe_n_i ? 1'bz : pin1_i;
   assign wire2_o = pin2_oe_n_i ? 1'bz : pin2_i;
endmodule
`default_nettype wire

/* File: verif/reset_alarm_pins_tb.sv */
// Purpose: Self-checking bench for the reset and alarm pin block
// Assumes: Soft reset wait shortened to 20 cycles
// Notes:   Read data is checked from a queue by a monitor
`timescale 1ns/1ps
`default_nettype none
module reset_alarm_pins_tb;
   import pinctl_pkg::*;
   localparam int unsigned WAIT_CYC = 20;
   logic        clk, arst_n, awvalid, wvalid, bready, arvalid, rready;
   logic        in1, in2, mid, hi, hold, busy, irq;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0]  bresp, rresp, clk_oe_n, ref_type;
   logic        p1, p1_oe_n, p2, p2_oe_n, pad_n, pad_drv, w1, w2;
   logic [33:0] expq[$];
   int          fails, checked;

   reset_alarm_pins #(.RST_WAIT_CYCLES(WAIT_CYC)) u_reset_alarm_pins (
      .CORE_CLK_I(clk), .ARST_N_I(arst_n),
      .AWVALID_I(awvalid), .AWREADY_O(awready), .AWADDR_I(awaddr),
      .WVALID_I(wvalid), .WREADY_O(wready), .WDATA_I(wdata), .WSTRB_I(4'hF),
      .BVALID_O(bvalid), .BREADY_I(bready), .BRESP_O(bresp),
      .ARVALID_I(arvalid), .ARREADY_O(arready), .ARADDR_I(araddr),
      .RVALID_O(rvalid), .RREADY_I(rready), .RDATA_O(rdata), .RRESP_O(rresp),
      .EXT_RESET_N_I(pad_n), .EXT_RESET_DRIVEN_I(pad_drv),
      .IN1_LOSS_I(in1), .IN2_LOSS_I(in2),
      .REF_LEVEL_MID_I(mid), .REF_LEVEL_HI_I(hi),
      .IRQ_OR_IN1_LOSS_OUT_O(p1), .IRQ_OR_IN1_LOSS_OE_N_O(p1_oe_n),
      .IN2_LOSS_OUT_O(p2), .IN2_LOSS_OE_N_O(p2_oe_n),
      .CLK_OUT_OE_N_O(clk_oe_n), .REF_TYPE_O(ref_type),
      .RESET_BUSY_O(busy), .IRQ_O(irq)
   );
   reset_host_model u_reset_host_model (
      .clk_i(clk), .hold_rst_i(hold), .pin1_i(p1), .pin1_oe_n_i(p1_oe_n),
      .pin2_i(p2), .pin2_oe_n_i(p2_oe_n), .pad_n_o(pad_n),
      .pad_drv_o(pad_drv), .wire1_o(w1), .wire2_o(w2)
   );

   task automatic check(input string what, input logic [33:0] seen,
                        input logic [33:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   function automatic logic [33:0] okw(input logic [7:0] v);
      return {RESP_OKAY, 24'h00_0000, v};
   endfunction
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
      @(posedge clk);
      awvalid <= 1'b1;
      awaddr  <= a;
      wvalid  <= 1'b1;
      wdata   <= {24'h00_0000, d};
      bready  <= 1'b1;
      fork
         begin
            do @(posedge clk); while (awready !== 1'b1);
            awvalid <= 1'b0;
         end
         begin
            do @(posedge clk); while (wready !== 1'b1);
            wvalid <= 1'b0;
         end
      join
      while (bvalid !== 1'b1) @(posedge clk);
      bready <= 1'b0;
      check("bresp", 34'(bresp), 34'(er));
   endtask
   task automatic rd(input logic [7:0] a, input logic [33:0] exp);
      @(posedge clk);
      arvalid <= 1'b1;
      araddr  <= a;
      rready  <= 1'b1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      expq.push_back(exp);
      do @(posedge clk); while (rvalid !== 1'b1);
      rready <= 1'b0;
   endtask
   // Expected pin states from control bits, loss levels and interrupt
   task automatic pins(input logic [7:0] c, input logic l1, input logic l2,
                       input logic iq);
      logic [1:0] e1;
      logic [1:0] e2;
      e1 = c[0] ? {1'b0, ~(iq ^ c[1])} : (c[2] ? {1'b0, ~(l1 ^ c[4])} : 2'b10);
      e2 = c[3] ? {1'b0, ~(l2 ^ c[4])} : 2'b10;
      check("pin1", 34'({p1_oe_n, p1}), 34'(e1));
      check("pin1 wire", 34'(w1), e1[1] ? 34'(1'bz) : 34'(e1[0]));
      check("pin2", 34'({p2_oe_n, p2}), 34'(e2));
      check("pin2 wire", 34'(w2), e2[1] ? 34'(1'bz) : 34'(e2[0]));
      check("clk oe", 34'(clk_oe_n), c[5] ? 34'(2'b00) : 34'(2'b11));
      check("irq", 34'(irq), 34'(iq));
   endtask

   always @(posedge clk) begin
      if (rvalid === 1'b1 && rready === 1'b1) begin
         check("rdata", {rresp, rdata}, expq.pop_front());
      end
   end
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Whole run is under a thousand cycles
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      test_done();
   end
   initial begin
      logic [7:0] c;
      logic       l1;
      logic       l2;
      {arst_n, awvalid, wvalid, bready, arvalid, rready, hold} = '0;
      {in1, in2, mid, hi, awaddr, araddr, wdata} = '0;
      void'($urandom(56));
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      repeat (4) @(posedge clk);
      pins(8'h00, 1'b0, 1'b0, 1'b0);
      rd(CTRL_OFFSET, okw(8'h00));
      rd(IRQ_MASK_OFFSET, okw(8'h00));
      rd(8'h10, {RESP_SLVERR, 32'h0000_0000});
      wr(8'h10, 8'hFF, RESP_SLVERR);
      for (int i = 0; i < 3; i++) begin
         mid <= (i != 0);
         hi  <= (i == 2);
         repeat (8) @(posedge clk);
         check("ref type", 34'(ref_type), 34'(i));
      end
      for (int n = 0; n < 32; n++) begin
         c  = {2'b00, 6'($urandom())};
         l1 = 1'($urandom());
         l2 = 1'($urandom());
         wr(CTRL_OFFSET, c, RESP_OKAY);
         in1 <= l1;
         in2 <= l2;
         repeat (8) @(posedge clk);
         pins(c, l1, l2, 1'b0);
         rd(CTRL_OFFSET, okw(c));
         rd(STATUS_OFFSET, okw({2'b00, c[5], 3'b010, l2, l1}));
      end
      wr(CTRL_OFFSET, 8'h03, RESP_OKAY);
      in1 <= 1'b0;
      in2 <= 1'b0;
      repeat (8) @(posedge clk);
      wr(IRQ_STATUS_OFFSET, 8'h0F, RESP_OKAY);
      wr(IRQ_MASK_OFFSET, 8'h01, RESP_OKAY);
      in1 <= 1'b1;
      repeat (8) @(posedge clk);
      pins(8'h03, 1'b1, 1'b0, 1'b1);
      rd(IRQ_STATUS_OFFSET, okw(8'h01));
      wr(STATUS_OFFSET, 8'hFF, RESP_OKAY);
      wr(IRQ_MASK_OFFSET, 8'h00, RESP_OKAY);
      wr(CTRL_OFFSET, 8'h01, RESP_OKAY);
      repeat (2) @(posedge clk);
      pins(8'h01, 1'b1, 1'b0, 1'b0);
      wr(IRQ_MASK_OFFSET, 8'h01, RESP_OKAY);
      repeat (2) @(posedge clk);
      pins(8'h01, 1'b1, 1'b0, 1'b1);
      wr(IRQ_STATUS_OFFSET, 8'h01, RESP_OKAY);
      repeat (2) @(posedge clk);
      pins(8'h01, 1'b1, 1'b0, 1'b0);
      rd(IRQ_STATUS_OFFSET, okw(8'h00));
      wr(CTRL_OFFSET, 8'h3C, RESP_OKAY);
      pins(8'h3C, 1'b1, 1'b0, 1'b0);
      hold <= 1'b1;
      repeat (10) @(posedge clk);
      check("busy", 34'(busy), 34'(1'b1));
      pins(8'h00, 1'b1, 1'b0, 1'b0);
      rd(CTRL_OFFSET, okw(8'h00));
      hold <= 1'b0;
      repeat (8) @(posedge clk);
      check("busy", 34'(busy), 34'(1'b0));
      rd(IRQ_MASK_OFFSET, okw(8'h00));
      wr(CTRL_OFFSET, 8'h24, RESP_OKAY);
      wr(CTRL_OFFSET, 8'hA4, RESP_OKAY);
      check("busy", 34'(busy), 34'(1'b1));
      pins(8'h00, 1'b1, 1'b0, 1'b0);
      repeat (WAIT_CYC - 4) @(posedge clk);
      check("busy", 34'(busy), 34'(1'b1));
      repeat (8) @(posedge clk);
      check("busy", 34'(busy), 34'(1'b0));
      rd(CTRL_OFFSET, okw(8'h00));
      repeat (4) @(posedge clk);
      test_done();
   end
endmodule
`default_nettype wire
